// ---- rtl/hps_pkg.sv ----
// Constants shared by both ends of the parallel host port
// Contract
// - Address strobe falling edge captures select inputs
// - Host asserts address strobe before latest strobe
// - Without address strobe, last active strobe captures
// - Byte identify low first byte, high second
// - Byte order bit decides which half first
// - Select inputs route to pointer, data, control
// - Codes 00 ctrl, 01 inc, 10 ptr, 11 data
// - Chip select low through access, may stay
// - Falling chip select samples if strobe active
// - Float data bus unless outputting read data
// - Two strobes wired, single strobe ties other high
// - Host always drives direction input
// - Data strobes combined by exclusive-NOR
// - Interrupt output follows control register bit
// - Interrupt output high during reset
// - Direction high reads, low writes
// - Ready high when idle, forced high deselected
// - Accesses synchronized to device clock
package hps_pkg;

  // ===========================================================
  // Register select codes
  localparam logic [1:0] SEL_CTRL     = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_POINTER  = 2'h2;
  localparam logic [1:0] SEL_DATA     = 2'h3;

  // ===========================================================
  // Control register bit positions
  localparam int CTRL_FIRST_HIGH_BIT = 0;
  localparam int CTRL_HOST_IRQ_BIT   = 3;
  localparam int CTRL_DEV_IRQ_BIT    = 1;
  localparam logic [7:0] CTRL_RESET  = 8'h08;

  // ===========================================================
  // Timing counts
  localparam logic [3:0] BUSY_CYCLES = 4'h5;
  localparam logic [3:0] STROBE_HOLD = 4'h3;

endpackage

// ---- rtl/hps_if.sv ----
// Pin level interface between host and the parallel port
`timescale 1ns/1ps
interface hps_if;
  logic       addr_strobe_n;
  logic       port_select_n;
  logic       data_strobe_a;
  logic       data_strobe_b;
  logic       transfer_direction;
  logic       byte_order_ident;
  logic [1:0] host_reg_select;
  logic [7:0] host_byte_dev;
  logic       host_byte_dev_oe;
  logic [7:0] host_byte_host;
  logic       host_byte_host_oe;
  logic       host_irq_out;
  logic       port_ready_out;

  modport dev (
    input  addr_strobe_n, port_select_n, data_strobe_a, data_strobe_b,
    input  transfer_direction, byte_order_ident, host_reg_select,
    input  host_byte_host,
    output host_byte_dev, host_byte_dev_oe, host_irq_out, port_ready_out
  );
  modport host (
    output addr_strobe_n, port_select_n, data_strobe_a, data_strobe_b,
    output transfer_direction, byte_order_ident, host_reg_select,
    output host_byte_host, host_byte_host_oe,
    input  host_byte_dev, host_irq_out, port_ready_out
  );
endinterface

// ---- rtl/hps_device.sv ----
// Device end: samples host pins, decodes accesses, drives bus
`timescale 1ns/1ps
module hps_device #(
  parameter int ADDR_W = 11
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  hps_if.dev                     pins,
  input  wire logic              dev_irq_set_i,
  input  wire logic [15:0]       mem_rdata_i,
  output logic                   mem_we_o,
  output logic                   mem_re_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic [15:0]            mem_wdata_o,
  output logic                   host_to_dev_irq_o
);

  // ===========================================================
  // Elaboration check
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // ===========================================================
  // Two-flop synchronisers for all host inputs
  logic [7:0]  s1_reg, s2_reg;
  logic [7:0]  s1_next;
  logic [7:0]  d1_reg, d2_reg;
  always_comb begin
    s1_next = {pins.addr_strobe_n, pins.port_select_n, pins.data_strobe_a,
               pins.data_strobe_b, pins.transfer_direction,
               pins.byte_order_ident, pins.host_reg_select};
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= 8'hC0;
      s2_reg <= 8'hC0;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s1_reg;
      d1_reg <= pins.host_byte_host;
      d2_reg <= d1_reg;
    end
  end

  logic       as_n, cs_n, dsa, dsb, dir, bil;
  logic [1:0] sel;
  assign {as_n, cs_n, dsa, dsb, dir, bil, sel} = s2_reg;

  // Combined access strobe: select low and XNOR of strobes low
  logic strobe_n;
  assign strobe_n = cs_n | ~(dsa ^ dsb);

  // ===========================================================
  // Strobe and address strobe edge tracking
  logic strobe_n_reg, as_n_reg;
  logic act;
  assign act = strobe_n_reg & ~strobe_n;    // access begins
  logic fin;
  assign fin = ~strobe_n_reg & strobe_n;    // access ends

  // Latched control fields
  logic       lat_dir_reg, lat_bil_reg, lat_dir_next, lat_bil_next;
  logic [1:0] lat_sel_reg, lat_sel_next;
  logic       as_lat_reg, as_lat_next;
  always_comb begin
    lat_dir_next = lat_dir_reg;
    lat_bil_next = lat_bil_reg;
    lat_sel_next = lat_sel_reg;
    as_lat_next  = as_lat_reg;
    if (as_n_reg && !as_n) begin
      lat_dir_next = dir;
      lat_bil_next = bil;
      lat_sel_next = sel;
      as_lat_next  = 1'b1;
    end else if (act && !as_lat_reg) begin
      lat_dir_next = dir;
      lat_bil_next = bil;
      lat_sel_next = sel;
    end
    if (fin) begin
      as_lat_next = 1'b0;
    end
  end

  // ===========================================================
  // Port registers and access engine
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [7:0]  first_reg, first_next;
  logic [15:0] rd_reg, rd_next;
  logic [7:0]  dout_reg, dout_next;
  logic        oe_reg, oe_next;
  logic [3:0]  busy_reg, busy_next;
  logic        we_next, re_next, hirq_next;
  logic        we_reg, re_reg, hirq_reg;
  logic [15:0] wd_reg, wd_next;
  logic [15:0] word;
  logic        fh;
  logic        data_sel;

  // Pointer step, full 16 bits wrap
  function automatic logic [15:0] ptr_step(input logic [15:0] v);
    return v + 16'h0001;
  endfunction

  always_comb begin
    ctrl_next  = ctrl_reg;
    ptr_next   = ptr_reg;
    first_next = first_reg;
    rd_next    = rd_reg;
    dout_next  = dout_reg;
    oe_next    = oe_reg;
    busy_next  = (busy_reg != 4'h0) ? busy_reg - 4'h1 : 4'h0;
    we_next    = 1'b0;
    re_next    = 1'b0;
    hirq_next  = 1'b0;
    wd_next    = wd_reg;
    fh         = ctrl_reg[hps_pkg::CTRL_FIRST_HIGH_BIT];
    data_sel   = lat_sel_next[0];
    word       = 16'h0000;
    if (dev_irq_set_i) begin
      ctrl_next[hps_pkg::CTRL_HOST_IRQ_BIT] = 1'b1;
    end
    if (act) begin
      busy_next = hps_pkg::BUSY_CYCLES;
      if (lat_dir_next) begin
        // Read: pick the byte of the selected word
        case (lat_sel_next)
          hps_pkg::SEL_CTRL:    word = {ctrl_reg, ctrl_reg};
          hps_pkg::SEL_POINTER: word = ptr_reg;
          default:              word = rd_reg;
        endcase
        dout_next = (lat_bil_next ^ fh) ? word[15:8] : word[7:0];
        oe_next   = 1'b1;
      end else if (!lat_bil_next) begin
        first_next = d2_reg;
      end else begin
        word = fh ? {first_reg, d2_reg} : {d2_reg, first_reg};
        case (lat_sel_next)
          hps_pkg::SEL_CTRL: begin
            // Host writes 1 to clear host irq, sets device irq
            if (word[hps_pkg::CTRL_HOST_IRQ_BIT]) begin
              ctrl_next[hps_pkg::CTRL_HOST_IRQ_BIT] = dev_irq_set_i;
            end
            ctrl_next[hps_pkg::CTRL_FIRST_HIGH_BIT] =
              word[hps_pkg::CTRL_FIRST_HIGH_BIT];
            hirq_next = word[hps_pkg::CTRL_DEV_IRQ_BIT];
          end
          hps_pkg::SEL_POINTER: begin
            ptr_next = word;
            re_next  = 1'b1;
          end
          hps_pkg::SEL_DATA_INC: begin
            ptr_next = ptr_step(ptr_reg);   // Preincrement on write
            we_next  = 1'b1;
            wd_next  = word;
          end
          default: begin
            we_next = 1'b1;
            wd_next = word;
          end
        endcase
      end
      if (lat_dir_next && lat_bil_next && data_sel) begin
        re_next = 1'b1;
        if (lat_sel_next == hps_pkg::SEL_DATA_INC) begin
          ptr_next = ptr_step(ptr_reg);     // Postincrement on read
        end
      end
    end
    if (re_reg) begin
      rd_next = mem_rdata_i;
    end
    if (strobe_n) begin
      oe_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_n_reg <= 1'b1;
      as_n_reg     <= 1'b1;
      lat_dir_reg  <= 1'b1;
      lat_bil_reg  <= 1'b0;
      lat_sel_reg  <= 2'h0;
      as_lat_reg   <= 1'b0;
      ctrl_reg     <= hps_pkg::CTRL_RESET;
      ptr_reg      <= 16'h0000;
      first_reg    <= 8'h00;
      rd_reg       <= 16'h0000;
      dout_reg     <= 8'h00;
      oe_reg       <= 1'b0;
      busy_reg     <= 4'h0;
      we_reg       <= 1'b0;
      re_reg       <= 1'b0;
      hirq_reg     <= 1'b0;
      wd_reg       <= 16'h0000;
    end else begin
      strobe_n_reg <= strobe_n;
      as_n_reg     <= as_n;
      lat_dir_reg  <= lat_dir_next;
      lat_bil_reg  <= lat_bil_next;
      lat_sel_reg  <= lat_sel_next;
      as_lat_reg   <= as_lat_next;
      ctrl_reg     <= ctrl_next;
      ptr_reg      <= ptr_next;
      first_reg    <= first_next;
      rd_reg       <= rd_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      busy_reg     <= busy_next;
      we_reg       <= we_next;
      re_reg       <= re_next;
      hirq_reg     <= hirq_next;
      wd_reg       <= wd_next;
    end
  end

  // Ready: deselected forces high, busy drops it
  logic rdy_reg, rdy_next;
  always_comb begin
    rdy_next = cs_n | (busy_next == 4'h0);
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_reg <= 1'b1;
    end else begin
      rdy_reg <= rdy_next;
    end
  end

  // ===========================================================
  // Outputs
  assign pins.host_byte_dev    = dout_reg;
  assign pins.host_byte_dev_oe = oe_reg;
  assign pins.host_irq_out     = ctrl_reg[hps_pkg::CTRL_HOST_IRQ_BIT];
  assign pins.port_ready_out   = rdy_reg;
  assign mem_we_o              = we_reg;
  assign mem_re_o              = re_reg;
  assign mem_addr_o            = ptr_reg[ADDR_W-1:0];
  assign mem_wdata_o           = wd_reg;
  assign host_to_dev_irq_o     = hirq_reg;

endmodule

// ---- rtl/hps_host.sv ----
// Host end: drives one two-byte word access over the pins
`timescale 1ns/1ps
module hps_host (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  hps_if.host              pins,
  input  wire logic        req_i,
  input  wire logic        dir_read_i,
  input  wire logic [1:0]  sel_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o
);

  typedef enum logic [3:0] {
    HH_IDLE  = 4'h1,
    HH_STRB  = 4'h2,
    HH_GAP   = 4'h4,
    HH_WAIT  = 4'h8
  } hps_hh_state_e;

  hps_hh_state_e st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        bil_reg, bil_next;
  logic        dir_reg, dir_next;
  logic [1:0]  sel_reg, sel_next;
  logic [15:0] wd_reg, wd_next, rd_reg, rd_next;
  logic        done_next, done_reg;
  logic [1:0]  rdy_sync_reg;
  logic [7:0]  dq1_reg, dq2_reg;

  // Synchronise ready and read data
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_sync_reg <= 2'h0;
      dq1_reg      <= 8'h00;
      dq2_reg      <= 8'h00;
    end else begin
      rdy_sync_reg <= {rdy_sync_reg[0], pins.port_ready_out};
      dq1_reg      <= pins.host_byte_dev;
      dq2_reg      <= dq1_reg;
    end
  end

  // Access sequencer: two bytes, first then second
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    bil_next  = bil_reg;
    dir_next  = dir_reg;
    sel_next  = sel_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    done_next = 1'b0;
    case (st_reg)
      HH_IDLE: begin
        if (req_i) begin
          dir_next = dir_read_i;
          sel_next = sel_i;
          wd_next  = wdata_i;
          bil_next = 1'b0;
          cnt_next = hps_pkg::STROBE_HOLD + 4'h2;
          st_next  = HH_STRB;
        end
      end
      HH_STRB: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          if (bil_reg) begin
            rd_next[7:0] = dq2_reg;
          end else begin
            rd_next[15:8] = dq2_reg;
          end
          st_next = HH_GAP;
        end
      end
      HH_GAP: begin
        st_next = HH_WAIT;
      end
      HH_WAIT: begin
        if (rdy_sync_reg[1]) begin
          if (bil_reg) begin
            done_next = 1'b1;
            st_next   = HH_IDLE;
          end else begin
            bil_next = 1'b1;
            cnt_next = hps_pkg::STROBE_HOLD + 4'h2;
            st_next  = HH_STRB;
          end
        end
      end
      default: st_next = HH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg   <= HH_IDLE;
      cnt_reg  <= 4'h0;
      bil_reg  <= 1'b0;
      dir_reg  <= 1'b1;
      sel_reg  <= 2'h0;
      wd_reg   <= 16'h0000;
      rd_reg   <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bil_reg  <= bil_next;
      dir_reg  <= dir_next;
      sel_reg  <= sel_next;
      wd_reg   <= wd_next;
      rd_reg   <= rd_next;
      done_reg <= done_next;
    end
  end

  // Pin drive: chip select held low, second strobe tied high
  logic strb;
  assign strb = (st_reg == HH_STRB);
  assign pins.addr_strobe_n      = 1'b1;
  assign pins.port_select_n      = (st_reg == HH_IDLE);
  assign pins.data_strobe_a      = ~strb;
  assign pins.data_strobe_b      = 1'b1;
  assign pins.transfer_direction = dir_reg;
  assign pins.byte_order_ident   = bil_reg;
  assign pins.host_reg_select    = sel_reg;
  assign pins.host_byte_host     = bil_reg ? wd_reg[7:0] : wd_reg[15:8];
  assign pins.host_byte_host_oe  = strb & ~dir_reg;
  assign busy_o                  = (st_reg != HH_IDLE);
  assign done_o                  = done_reg;
  assign rdata_o                 = rd_reg;

endmodule

// ---- tb/hps_sva.sv ----
// Concurrent checks on the pins between host end and device end
`timescale 1ns/1ps
module hps_sva (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic port_select_n,
  input wire logic data_strobe_a,
  input wire logic data_strobe_b,
  input wire logic transfer_direction,
  input wire logic byte_order_ident,
  input wire logic host_byte_dev_oe,
  input wire logic host_byte_host_oe,
  input wire logic host_irq_out,
  input wire logic port_ready_out
);
  // ===========================================================
  // Helper state
  logic idle;
  logic idle_reg;
  logic idle_next;
  logic last_id_reg;
  logic last_id_next;

  // Combined strobe as the device sees it, inactive high
  assign idle = port_select_n | ~(data_strobe_a ^ data_strobe_b);

  // Byte identify seen at the most recent access start
  always_comb begin
    idle_next    = idle;
    last_id_next = (idle_reg && !idle) ? byte_order_ident : last_id_reg;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_reg    <= 1'b1;
      last_id_reg <= 1'b1;
    end else begin
      idle_reg    <= idle_next;
      last_id_reg <= last_id_next;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ===========================================================
  // Access sequences
  sequence acc_start;
    $fell(idle);
  endsequence
  sequence rd_start;
    acc_start ##0 transfer_direction;
  endsequence
  sequence wr_start;
    acc_start ##0 !transfer_direction;
  endsequence

  // ===========================================================
  // Assertions
  a_float_idle:
    assert property (idle [*5] |-> !host_byte_dev_oe)
    else $error("data bus driven while idle");
  a_no_bus_fight:
    assert property (host_byte_dev_oe |-> !host_byte_host_oe)
    else $error("both ends drive the data bus");
  a_read_drives_bus:
    assert property (rd_start |-> ##[1:4] host_byte_dev_oe)
    else $error("read access never drove the bus");
  a_write_keeps_off:
    assert property (wr_start |-> !host_byte_dev_oe [*5])
    else $error("bus driven during a write");
  a_ready_deselect:
    assert property (port_select_n [*3] |-> port_ready_out)
    else $error("ready low while deselected");
  a_ready_busy:
    assert property (acc_start |-> ##[0:6] !port_ready_out)
    else $error("ready never dropped after access");
  a_irq_in_reset:
    assert property (disable iff (1'b0) !rst_n_i |-> host_irq_out)
    else $error("interrupt output low in reset");
  a_byte_order_ident:
    assert property (acc_start |-> byte_order_ident != last_id_reg)
    else $error("byte identify out of order");
  a_dir_stable:
    assert property (!idle && !idle_reg |-> $stable(transfer_direction))
    else $error("direction changed inside access");
  a_select_held:
    assert property ((data_strobe_a ^ data_strobe_b) |-> !port_select_n)
    else $error("data strobe active without select");
endmodule

// ---- tb/tb_host_port_pin_sampling.sv ----
// Bench for host and device ends joined by the pin interface
`timescale 1ns/1ps
module tb_host_port_pin_sampling;
  localparam int AW = 4;
  logic        clk, rst_n_i, req, dir, irq_set, busy, done, we, re, d_irq;
  logic [1:0]  sel;
  logic [15:0] wdata, rdata, mem_rd, mwdata, r, w, p;
  logic [AW-1:0] addr, a;
  logic [15:0] mem [16];
  logic [15:0] exp [16];
  logic [31:0] seed;
  logic        m, sd;
  int          err_total, comparisons, cyc, dcount, rcount;

  hps_if if1();
  hps_if if2();
  hps_device #(.ADDR_W(AW)) i_hps_device (.core_clk_i(clk),
    .rst_n_i(rst_n_i), .pins(if1), .dev_irq_set_i(irq_set),
    .mem_rdata_i(mem_rd), .mem_we_o(we), .mem_re_o(re), .mem_addr_o(addr),
    .mem_wdata_o(mwdata), .host_to_dev_irq_o(d_irq));
  hps_host i_hps_host (.core_clk_i(clk), .rst_n_i(rst_n_i), .pins(if1),
    .req_i(req), .dir_read_i(dir), .sel_i(sel), .wdata_i(wdata),
    .busy_o(busy), .done_o(done), .rdata_o(rdata));
  // Second device is driven straight from the bench to break host habits
  hps_device #(.ADDR_W(AW)) i_hps_device_2 (.core_clk_i(clk),
    .rst_n_i(rst_n_i), .pins(if2), .dev_irq_set_i(1'b0),
    .mem_rdata_i(16'h0000), .mem_we_o(), .mem_re_o(), .mem_addr_o(),
    .mem_wdata_o(), .host_to_dev_irq_o());
  hps_sva i_hps_sva (.core_clk_i(clk), .rst_n_i(rst_n_i),
    .port_select_n(if1.port_select_n), .data_strobe_a(if1.data_strobe_a),
    .data_strobe_b(if1.data_strobe_b),
    .transfer_direction(if1.transfer_direction),
    .byte_order_ident(if1.byte_order_ident),
    .host_byte_dev_oe(if1.host_byte_dev_oe),
    .host_byte_host_oe(if1.host_byte_host_oe),
    .host_irq_out(if1.host_irq_out), .port_ready_out(if1.port_ready_out));

  // Shared memory model behind the first device
  assign mem_rd = mem[addr];
  always @(posedge clk) begin
    if (we) mem[addr] <= mwdata;
    if (d_irq) dcount++;
    if (re) rcount++;
  end

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      $display("wrong value at %0t ns: run timed out", $time);
      end_sim();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] swp(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction

  // Word as the host end sees it for a given first-byte-high setting
  function automatic logic [15:0] ord(input logic [15:0] v,
                                      input logic f);
    return f ? v : swp(v);
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string s);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t ns: %s", $time, s);
    end
  endtask

  // One word access through the host end, bounded wait for done
  task automatic hw(input logic [1:0] s, input logic d,
                    input logic [15:0] v);
    int n;
    @(negedge clk);
    req = 1'b1; sel = s; dir = d; wdata = v;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(16'(done), 16'h0001, "access never completed");
    chk(16'(busy), 16'h0000, "host busy after done");
    r = rdata;
  endtask

  // Two byte control read on the second device with chosen strobe wiring
  task automatic fr(input logic use_as, input logic sa, input logic sb,
                    input logic cs_last);
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      if2.byte_order_ident = k[0];
      if2.host_reg_select = hps_pkg::SEL_CTRL;
      if2.transfer_direction = 1'b1;
      @(negedge clk);
      if2.addr_strobe_n = !use_as;
      repeat (3) @(negedge clk);
      if (use_as) begin
        if2.host_reg_select = hps_pkg::SEL_POINTER;
        if2.transfer_direction = 1'b0;
      end
      if (cs_last) begin
        if2.data_strobe_a = sa; if2.data_strobe_b = sb;
      end else if2.port_select_n = 1'b0;
      @(negedge clk);
      if (cs_last) if2.port_select_n = 1'b0;
      else begin
        if2.data_strobe_a = sa; if2.data_strobe_b = sb;
      end
      repeat (4) @(negedge clk);
      chk({7'h00, if2.host_byte_dev_oe, if2.host_byte_dev},
          {8'h01, hps_pkg::CTRL_RESET},
          "control byte not driven");
      if2.port_select_n = 1'b1; if2.addr_strobe_n = 1'b1;
      if2.data_strobe_a = 1'b1; if2.data_strobe_b = 1'b1;
      repeat (8) @(negedge clk);
      chk(16'(if2.host_byte_dev_oe), 16'h0000, "bus not floated");
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 0; rst_n_i = 1; req = 0; dir = 0; sel = 0; wdata = 0;
    irq_set = 0; seed = 32'h0000EEB5; err_total = 0; comparisons = 0;
    cyc = 0; dcount = 0; rcount = 0;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    if2.addr_strobe_n = 1; if2.port_select_n = 1; if2.data_strobe_a = 1;
    if2.data_strobe_b = 1; if2.transfer_direction = 1;
    if2.byte_order_ident = 0; if2.host_reg_select = 0;
    if2.host_byte_host = 8'h00; if2.host_byte_host_oe = 0;
    // Clean reset edge ahead of the first clock edge
    #5 rst_n_i = 0;
    repeat (6) @(negedge clk);
    chk(16'(if1.host_irq_out), 16'h0001, "irq low in reset");
    rst_n_i = 1;
    hw(hps_pkg::SEL_CTRL, 1'b1, 16'h0000);
    chk(r, {2{hps_pkg::CTRL_RESET}}, "control reset value");
    hw(hps_pkg::SEL_CTRL, 1'b0, 16'h0808);
    repeat (4) @(negedge clk);
    chk(16'(if1.host_irq_out), 16'h0000, "irq not cleared");
    irq_set = 1;
    @(negedge clk);
    irq_set = 0;
    repeat (4) @(negedge clk);
    chk(16'(if1.host_irq_out), 16'h0001, "irq not set");
    hw(hps_pkg::SEL_CTRL, 1'b0, 16'h0A0A);
    repeat (4) @(negedge clk);
    chk(16'(dcount), 16'h0001, "device interrupt pulse count");
    chk(16'(if1.host_irq_out), 16'h0000, "irq not cleared");
    // Random pointer and data traffic, byte order flipped each pass
    for (int it = 0; it < 6; it++) begin
      m = it[0];
      hw(hps_pkg::SEL_CTRL, 1'b0, {7'h00, m, 7'h00, m});
      p = 16'(xs());
      hw(hps_pkg::SEL_POINTER, 1'b0, ord(p, m));
      for (int k = 1; k < 4; k++) begin
        w = 16'(xs());
        hw(hps_pkg::SEL_DATA_INC, 1'b0, w);
        exp[4'(p + 16'(k))] = w;
      end
      w = 16'(xs());
      a = 4'(p + 16'h0003);
      hw(hps_pkg::SEL_DATA, 1'b0, w);
      exp[a] = w;
      repeat (8) @(negedge clk);
      chk(mem[a], ord(w, m), "byte order in memory");
      hw(hps_pkg::SEL_POINTER, 1'b0, ord(p + 16'h0001, m));
      for (int k = 1; k < 4; k++) begin
        hw(hps_pkg::SEL_DATA_INC, 1'b1, 16'h0000);
        chk(r, exp[4'(p + 16'(k))], "read back data");
      end
      hw(hps_pkg::SEL_POINTER, 1'b1, 16'h0000);
      chk(r, ord(p + 16'h0004, m), "pointer after increments");
    end
    // Two pointer loads and three incrementing reads per pass
    chk(16'(rcount), 16'h001E, "memory read pulse count");
    // Strobe wiring cases on the second device
    fr(1'b0, 1'b0, 1'b1, 1'b0);
    fr(1'b0, 1'b1, 1'b0, 1'b1);
    fr(1'b0, 1'b1, 1'b0, 1'b0);
    fr(1'b1, 1'b1, 1'b0, 1'b0);
    @(negedge clk);
    if2.port_select_n = 0; if2.data_strobe_a = 0; if2.data_strobe_b = 0;
    sd = 0;
    repeat (8) begin
      @(negedge clk);
      sd = sd | if2.host_byte_dev_oe;
    end
    chk(16'(sd), 16'h0000, "both strobes low started access");
    if2.port_select_n = 1; if2.data_strobe_a = 1; if2.data_strobe_b = 1;
    end_sim();
  end
endmodule
